// File: design/fsc_ctrl.sv
// Host controller issuing flash command cycles from APB registers
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - Host recovers by reset command or pin
// - Sector select sits at A16 and above
// - Command pattern sits in A10 to A0
// - Host sets sector guards before lock clear
module fsc_ctrl
    import fsc_pkg::*;
#(
    parameter logic [19:0] POLL_MAX = 20'h186A0
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [ADDR_W-1:0]      fl_addr,
    input  wire logic [DATA_W-1:0] fl_dq_i,
    output logic [DATA_W-1:0]      fl_dq_o,
    output logic                   fl_dq_oe,
    output logic                   fl_ce_n,
    output logic                   fl_we_n,
    output logic                   fl_oe_n,
    output logic                   fl_rst_n,
    output logic                   fl_wp_n
);
    typedef enum logic [5:0] {
        S_IDLE     = 6'h01,
        S_CYC      = 6'h02,
        S_POLL_A   = 6'h04,
        S_POLL_B   = 6'h08,
        S_RST_LOW  = 6'h10,
        S_RST_WAIT = 6'h20
    } fsc_state_t;

    typedef struct packed {
        fsc_state_t          state;
        fsc_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   rdata;
        logic [DATA_W-1:0]   prev;
        logic [19:0]         poll_cnt;
        logic [7:0]          rst_cnt;
        logic                wp;
        logic                gcfg;
        logic                busy;
        logic                done;
        logic                tmo;
        logic                refused;
        logic                start;
        logic                rst_n;
        logic                wp_n;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } fsc_ctrl_st_t;

    localparam int RST_HOLD_M1 = int'(CYC_RST) - 1;

    fsc_ctrl_st_t     st_ff;
    fsc_ctrl_st_t     nxt_st;
    fsc_req_t         cyc_req;
    logic             cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic             apb_setup;
    logic             apb_wr;
    logic             go_req;
    fsc_op_t          go_op;

    // Map hit for an APB byte address
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == OFF_CTRL) || (a == OFF_ADDR) ||
                  (a == OFF_WDATA) || (a == OFF_RDATA) ||
                  (a == OFF_STAT) || (a == OFF_CFG);
    endfunction

    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && st_ff.pready && pwrite;
    assign go_req    = apb_wr && (paddr == OFF_CTRL) && pwdata[CTRL_GO];
    assign go_op     = fsc_op_t'(pwdata[CTRL_OP_LSB +: 2]);

    assign cyc_req.rd    = (st_ff.op != OP_WRITE);
    assign cyc_req.addr  = st_ff.addr;
    assign cyc_req.wdata = st_ff.wdata;

    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.start   = 1'b0;
        nxt_st.pready  = apb_setup;
        nxt_st.pslverr = apb_setup && !reg_hit(paddr);
        nxt_st.wp_n    = st_ff.wp;
        if (apb_setup)
        begin
            unique case (paddr)
                OFF_ADDR:  nxt_st.prdata = 32'(st_ff.addr);
                OFF_WDATA: nxt_st.prdata = 32'(st_ff.wdata);
                OFF_RDATA: nxt_st.prdata = 32'(st_ff.rdata);
                OFF_STAT:  nxt_st.prdata = 32'({st_ff.refused, st_ff.tmo,
                                                st_ff.done, st_ff.busy});
                OFF_CFG:   nxt_st.prdata = 32'({st_ff.gcfg, st_ff.wp});
                default:   nxt_st.prdata = 32'h0000_0000;
            endcase
        end
        if (apb_wr)
        begin
            unique case (paddr)
                OFF_ADDR:  nxt_st.addr  = fsc_pin_addr(pwdata);
                OFF_WDATA: nxt_st.wdata = pwdata[DATA_W-1:0];
                OFF_CFG:
                begin
                    nxt_st.wp   = pwdata[CFG_WP];
                    nxt_st.gcfg = pwdata[CFG_GCFG];
                end
                default: ;
            endcase
        end
        if (go_req)
        begin
            if (st_ff.busy)
                nxt_st.refused = 1'b1;
            else if (pwdata[CTRL_LOCKCLR] && !st_ff.gcfg)
                nxt_st.refused = 1'b1;
            else
            begin
                nxt_st.op      = go_op;
                nxt_st.busy    = 1'b1;
                nxt_st.done    = 1'b0;
                nxt_st.tmo     = 1'b0;
                nxt_st.refused = 1'b0;
                nxt_st.poll_cnt = 20'h00000;
                unique case (go_op)
                    OP_WRITE, OP_READ:
                    begin
                        nxt_st.start = 1'b1;
                        nxt_st.state = S_CYC;
                    end
                    OP_POLL:
                    begin
                        nxt_st.start = 1'b1;
                        nxt_st.state = S_POLL_A;
                    end
                    OP_HWRST:
                    begin
                        nxt_st.rst_n   = 1'b0;
                        nxt_st.rst_cnt = CYC_RST - 8'h01;
                        nxt_st.state   = S_RST_LOW;
                    end
                endcase
            end
        end
        unique case (st_ff.state)
            S_IDLE: ;
            S_CYC:
            begin
                if (cyc_done)
                begin
                    if (st_ff.op == OP_READ)
                        nxt_st.rdata = cyc_rdata;
                    nxt_st.busy  = 1'b0;
                    nxt_st.done  = 1'b1;
                    nxt_st.state = S_IDLE;
                end
            end
            S_POLL_A:
            begin
                if (cyc_done)
                begin
                    nxt_st.prev  = cyc_rdata;
                    nxt_st.start = 1'b1;
                    nxt_st.state = S_POLL_B;
                end
            end
            S_POLL_B:
            begin
                if (cyc_done)
                begin
                    nxt_st.rdata = cyc_rdata;
                    if (cyc_rdata[TOGGLE_BIT] == st_ff.prev[TOGGLE_BIT])
                    begin
                        nxt_st.busy  = 1'b0;
                        nxt_st.done  = 1'b1;
                        nxt_st.state = S_IDLE;
                    end
                    else if (st_ff.poll_cnt == POLL_MAX)
                    begin
                        nxt_st.busy  = 1'b0;
                        nxt_st.tmo   = 1'b1;
                        nxt_st.state = S_IDLE;
                    end
                    else
                    begin
                        nxt_st.poll_cnt = st_ff.poll_cnt + 20'h00001;
                        nxt_st.prev     = cyc_rdata;
                        nxt_st.start    = 1'b1;
                    end
                end
            end
            S_RST_LOW:
            begin
                if (st_ff.rst_cnt == 8'h00)
                begin
                    nxt_st.rst_n   = 1'b1;
                    nxt_st.rst_cnt = CYC_RST_RDY - 8'h01;
                    nxt_st.state   = S_RST_WAIT;
                end
                else
                    nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
            end
            S_RST_WAIT:
            begin
                if (st_ff.rst_cnt == 8'h00)
                begin
                    nxt_st.busy  = 1'b0;
                    nxt_st.done  = 1'b1;
                    nxt_st.state = S_IDLE;
                end
                else
                    nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
            end
            default:
                nxt_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff       <= '0;
            st_ff.state <= S_IDLE;
            st_ff.op    <= OP_WRITE;
            st_ff.wp    <= CFG_WP_RST;
            st_ff.gcfg  <= CFG_GCFG_RST;
            st_ff.rst_n <= 1'b1;
            st_ff.wp_n  <= CFG_WP_RST;
        end
        else
            st_ff <= nxt_st;
    end

    fsc_cycle u_cycle (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (st_ff.start),
        .req_in  (cyc_req),
        .dq_i    (fl_dq_i),
        .ce_n    (fl_ce_n),
        .we_n    (fl_we_n),
        .oe_n    (fl_oe_n),
        .addr    (fl_addr),
        .dq_o    (fl_dq_o),
        .dq_oe   (fl_dq_oe),
        .done    (cyc_done),
        .rdata   (cyc_rdata)
    );

    assign prdata   = st_ff.prdata;
    assign pready   = st_ff.pready;
    assign pslverr  = st_ff.pslverr;
    assign fl_rst_n = st_ff.rst_n;
    assign fl_wp_n  = st_ff.wp_n;

    rst_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fl_rst_n) |-> ##RST_HOLD_M1 !fl_rst_n ##1 fl_rst_n)
        else $error("Hardware reset pulse has the wrong width");

    rst_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fl_rst_n |-> fl_ce_n && fl_we_n)
        else $error("Bus cycle while flash reset is low");

    lock_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        (go_req && pwdata[CTRL_LOCKCLR] && !st_ff.gcfg && !st_ff.busy)
        |=> st_ff.refused && !st_ff.busy && st_ff.state == S_IDLE)
        else $error("Lock clear issued before guards were configured");

    addr_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fl_ce_n) |-> fl_addr == st_ff.addr)
        else $error("Pin address differs from programmed sector and pattern");

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("APB ready not one cycle after setup");
endmodule

// File: design/fsc_cycle.sv
// One asynchronous flash bus cycle: write strobe or read strobe
`timescale 1ns/100ps
module fsc_cycle
    import fsc_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              start,
    input  wire fsc_req_t          req_in,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic                   ce_n,
    output logic                   we_n,
    output logic                   oe_n,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata
);
    typedef enum logic [3:0] {
        PH_IDLE   = 4'h1,
        PH_SETUP  = 4'h2,
        PH_STROBE = 4'h4,
        PH_HOLD   = 4'h8
    } fsc_ph_t;

    typedef struct packed {
        fsc_ph_t             ph;
        logic [7:0]          cnt;
        fsc_req_t            req;
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic                dq_oe;
        logic                done;
        logic [DATA_W-1:0]   rdata;
        logic [DATA_W-1:0]   s1;
        logic [DATA_W-1:0]   s2;
    } fsc_cyc_st_t;

    localparam int PULSE_M1 = int'(CYC_PULSE) - 1;

    fsc_cyc_st_t st_ff;
    fsc_cyc_st_t nxt_st;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.s1   = dq_i;
        nxt_st.s2   = st_ff.s1;
        unique case (st_ff.ph)
            PH_IDLE:
            begin
                if (start)
                begin
                    nxt_st.req   = req_in;
                    nxt_st.ce_n  = 1'b0;
                    nxt_st.dq_oe = ~req_in.rd;
                    nxt_st.cnt   = CYC_SETUP - 8'h01;
                    nxt_st.ph    = PH_SETUP;
                end
            end
            PH_SETUP:
            begin
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.oe_n = ~st_ff.req.rd;
                    nxt_st.we_n = st_ff.req.rd;
                    nxt_st.cnt  = st_ff.req.rd ? CYC_READ - 8'h01
                                               : CYC_PULSE - 8'h01;
                    nxt_st.ph   = PH_STROBE;
                end
                else
                    nxt_st.cnt = st_ff.cnt - 8'h01;
            end
            PH_STROBE:
            begin
                if (st_ff.cnt == 8'h00)
                begin
                    if (st_ff.req.rd)
                        nxt_st.rdata = st_ff.s2;
                    nxt_st.we_n = 1'b1;
                    nxt_st.oe_n = 1'b1;
                    nxt_st.cnt  = CYC_HOLD - 8'h01;
                    nxt_st.ph   = PH_HOLD;
                end
                else
                    nxt_st.cnt = st_ff.cnt - 8'h01;
            end
            PH_HOLD:
            begin
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.ce_n  = 1'b1;
                    nxt_st.dq_oe = 1'b0;
                    nxt_st.done  = 1'b1;
                    nxt_st.ph    = PH_IDLE;
                end
                else
                    nxt_st.cnt = st_ff.cnt - 8'h01;
            end
            default:
                nxt_st.ph = PH_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff       <= '0;
            st_ff.ph    <= PH_IDLE;
            st_ff.ce_n  <= 1'b1;
            st_ff.we_n  <= 1'b1;
            st_ff.oe_n  <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign ce_n  = st_ff.ce_n;
    assign we_n  = st_ff.we_n;
    assign oe_n  = st_ff.oe_n;
    assign addr  = st_ff.req.addr;
    assign dq_o  = st_ff.req.wdata;
    assign dq_oe = st_ff.dq_oe;
    assign done  = st_ff.done;
    assign rdata = st_ff.rdata;

    addr_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!ce_n && !$fell(ce_n)) |-> $stable(addr))
        else $error("Sector or pattern address moved inside a cycle");

    we_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(we_n) |-> ##PULSE_M1 !we_n ##1 we_n)
        else $error("Write strobe width wrong");

    done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> ##1 !done && ce_n)
        else $error("Cycle done not a single pulse");
endmodule

// File: design/fsc_pkg.sv
// Constants, types and helpers shared by the sector guard controller
package fsc_pkg;
    // Clock and timing
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          T_SETUP_NS    = 10;
    localparam int          T_PULSE_NS    = 35;
    localparam int          T_READ_NS     = 100;
    localparam int          T_HOLD_NS     = 20;
    localparam int          T_RST_NS      = 500;
    localparam int          T_RST_RDY_NS  = 200;
    localparam logic [7:0]  CYC_SETUP = 8'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0]  CYC_PULSE = 8'((T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0]  CYC_READ  = 8'((T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0]  CYC_HOLD  = 8'((T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0]  CYC_RST   = 8'((T_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0]  CYC_RST_RDY = 8'((T_RST_RDY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Flash pin widths and address fields
    localparam int          ADDR_W     = 26;
    localparam int          DATA_W     = 16;
    localparam int          SECT_LSB   = 16;
    localparam int          PAT_MSB    = 10;
    localparam int          TOGGLE_BIT = 6;

    // Register offsets
    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_ADDR  = 12'h004;
    localparam logic [11:0] OFF_WDATA = 12'h008;
    localparam logic [11:0] OFF_RDATA = 12'h00C;
    localparam logic [11:0] OFF_STAT  = 12'h010;
    localparam logic [11:0] OFF_CFG   = 12'h014;

    // Control fields
    localparam int          CTRL_GO      = 0;
    localparam int          CTRL_OP_LSB  = 1;
    localparam int          CTRL_LOCKCLR = 3;
    // Configuration fields and reset values
    localparam int          CFG_WP       = 0;
    localparam int          CFG_GCFG     = 1;
    localparam logic        CFG_WP_RST   = 1'b1;
    localparam logic        CFG_GCFG_RST = 1'b0;
    // Status fields
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_DONE    = 1;
    localparam int          STAT_TMO     = 2;
    localparam int          STAT_REFUSED = 3;

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ  = 2'h1,
        OP_POLL  = 2'h2,
        OP_HWRST = 2'h3
    } fsc_op_t;

    typedef struct packed {
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } fsc_req_t;

    // Word address: sector select at SECT_LSB and above, command pattern below
    function automatic logic [ADDR_W-1:0] fsc_pin_addr(
        input logic [31:0] r
    );
        fsc_pin_addr = r[ADDR_W-1:0];
    endfunction
endpackage

// File: tb/fsc_ctrl_tb_top.sv
// Self-checking bench for the sector guard controller
`timescale 1ns/100ps
module fsc_ctrl_tb_top
    import fsc_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, st, q, q2;
    logic              pready, pslverr, e;
    logic [ADDR_W-1:0] fl_addr;
    logic [DATA_W-1:0] fl_dq_i, fl_dq_o;
    logic              fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
    logic              fl_rst_n, fl_wp_n;
    int                n_fail, n_checks;

    fsc_ctrl #(.POLL_MAX(20'h00008)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fl_addr(fl_addr), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n), .fl_rst_n(fl_rst_n), .fl_wp_n(fl_wp_n));
    fsc_flash_model flash (
        .addr(fl_addr), .dq_in(fl_dq_o), .dq_out(fl_dq_i),
        .dq_oe(fl_dq_oe),
        .ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
        .rst_n(fl_rst_n), .wp_n(fl_wp_n));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, pready, 1'b1);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Poll the status word until the operation settles
    task automatic wait_st;
        int n;
        n = 0;
        st = 32'h0;
        while (st[3:1] == 3'h0 && n < 300)
        begin
            apb(1'b0, OFF_STAT, 32'h0);
            st = q;
            n++;
        end
        if (st[3:1] === 3'h0)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, st, 32'h2);
        end
    endtask

    // Issue one flash operation and wait for its status
    task automatic go(input logic [1:0] op, input logic [31:0] a,
                      input logic [31:0] d, input logic lc);
        apb(1'b1, OFF_ADDR, a);
        apb(1'b1, OFF_WDATA, d);
        apb(1'b1, OFF_CTRL, {28'h0, lc, op, 1'b1});
        wait_st();
    endtask

    task automatic cmd(input logic [7:0] c, input logic [1:0] s,
                       input logic [15:0] d);
        go(2'h0, 32'h555, {24'h0, c}, 1'b0);
        go(2'h0, {14'h0, s, 16'h0}, {16'h0, d}, 1'b0);
    endtask

    task automatic frd(input logic [1:0] s);
        go(2'h1, {14'h0, s, 16'h0}, 32'h0, 1'b0);
        apb(1'b0, OFF_RDATA, 32'h0);
    endtask

    task automatic t_reset;
        apb(1'b0, OFF_CFG, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk({q[30:0], e}, 32'h1);
        chk({fl_wp_n, fl_rst_n, fl_ce_n}, 32'h7);
    endtask

    task automatic t_prog;
        cmd(8'hA0, 2'h2, 16'h1234);
        frd(2'h2);
        chk(q, 32'h1234);
        go(2'h0, 32'h554, 32'hA0, 1'b0);
        go(2'h0, 32'h20000, 32'h5555, 1'b0);
        frd(2'h2);
        chk(q, 32'h1234);
    endtask

    task automatic t_wp;
        apb(1'b1, OFF_CFG, 32'h0);
        cmd(8'hA0, 2'h0, 16'hABCD);
        chk({31'h0, fl_wp_n}, 32'h0);
        frd(2'h0);
        chk(q, 32'hFFFF);
        apb(1'b1, OFF_CFG, 32'h1);
        cmd(8'hA0, 2'h0, 16'hABCD);
        frd(2'h0);
        chk(q, 32'hABCD);
    endtask

    task automatic t_guard;
        cmd(8'h60, 2'h3, 16'h0);
        cmd(8'hA0, 2'h3, 16'h1111);
        frd(2'h3);
        chk(q, 32'hFFFF);
        cmd(8'h60, 2'h3, 16'h1);
        cmd(8'hA0, 2'h3, 16'h2222);
        frd(2'h3);
        chk(q, 32'h2222);
        cmd(8'hC0, 2'h1, 16'h0);
        frd(2'h1);
        q2 = q;
        frd(2'h1);
        chk((q ^ q2) & 32'h40, 32'h40);
        go(2'h2, 32'h10000, 32'h0, 1'b0);
        chk(st & 32'hE, 32'h2);
        cmd(8'hA0, 2'h1, 16'h3333);
        frd(2'h1);
        chk(q, 32'hFFFF);
        go(2'h0, 32'h0, 32'h0, 1'b1);
        chk(st & 32'h8, 32'h8);
        apb(1'b1, OFF_CFG, 32'h3);
        go(2'h0, 32'h555, 32'h50, 1'b0);
        go(2'h0, 32'h0, 32'h0, 1'b1);
        chk(st & 32'hE, 32'h2);
        cmd(8'h80, 2'h0, 16'h0);
        go(2'h2, 32'h0, 32'h0, 1'b0);
        cmd(8'hA0, 2'h1, 16'h4444);
        frd(2'h1);
        chk(q, 32'hFFFF);
        apb(1'b1, OFF_CTRL, 32'h7);
        repeat (4) @(posedge pclk);
        chk({31'h0, fl_rst_n}, 32'h0);
        wait_st();
        chk(st & 32'hE, 32'h2);
        cmd(8'h80, 2'h0, 16'h0);
        go(2'h2, 32'h0, 32'h0, 1'b0);
        cmd(8'hA0, 2'h1, 16'h4444);
        frd(2'h1);
        chk(q, 32'h4444);
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        n_fail = 0;
        n_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_prog();
        t_wp();
        t_guard();
        end_of_test();
    end

    initial
    begin
        #100000;
        n_fail++;
        end_of_test();
    end
endmodule

// File: tb/fsc_flash_model.sv
// Behavioural flash device with sector guards on the controller's pins
`timescale 1ns/100ps
module fsc_flash_model
    import fsc_pkg::*;
#(
    parameter bit PWD_MODE = 1'b0
)
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              dq_oe,
    output logic [DATA_W-1:0]      dq_out,
    input  wire logic              ce_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic              rst_n,
    input  wire logic              wp_n
);
    logic [DATA_W-1:0] mem [4];
    logic [3:0]        nv_g;
    logic [3:0]        v_g;
    logic              lock;
    logic [7:0]        op;
    int                busy;
    logic [DATA_W-1:0] rdv;
    logic [1:0]        s;
    assign s = addr[SECT_LSB+1:SECT_LSB];
    // Released bus shows the inverse of the last word
    assign dq_out = (!ce_n && !oe_n) ? rdv : ~rdv;
    function automatic logic open_s(input logic [1:0] k);
        open_s = nv_g[k] & v_g[k] & !(k == 2'h0 && !wp_n);
    endfunction
    initial
    begin
        mem = '{default: 16'hFFFF};
        nv_g = 4'hF;
        rdv = 16'hFFFF;
        op = 8'h00;
        v_g = 4'hF;
        lock = !PWD_MODE;
        busy = 0;
    end
    // Reset: decoder idle, volatile guards open, lock per method
    always @(negedge rst_n)
    begin
        op = 8'h00;
        v_g = 4'hF;
        lock = !PWD_MODE;
        busy = 0;
    end
    always @(posedge we_n)
    begin
        if (!ce_n && rst_n && dq_oe && op == 8'h00 &&
            addr[PAT_MSB:0] == 11'h555)
            op = dq_in[7:0];
        else if (!ce_n && rst_n && dq_oe && op != 8'h00)
        begin
            case (op)
                8'hA0: if (open_s(s)) mem[s] = dq_in;
                8'h60: v_g[s] = dq_in[0];
                8'hC0:
                begin
                    nv_g[s] = nv_g[s] & !lock;
                    busy = 3;
                end
                8'h80:
                begin
                    nv_g = nv_g | {4{lock}};
                    busy = 3;
                end
                8'h50: lock = 1'b0;
                default: ;
            endcase
            op = 8'h00;
        end
    end
    always @(negedge oe_n)
    begin
        if (!ce_n && busy > 0)
        begin
            rdv = rdv ^ 16'h0040;
            busy = busy - 1;
        end
        else if (!ce_n)
            rdv = mem[s];
    end
endmodule
